/* bench/serial_chan_ctrl_chk.sv */
// Purpose: port checks for serial_chan_ctrl
// Assumes: one clock, nrst_i async active low
// Notes: bound into every serial_chan_ctrl
`timescale 1ns/1ps
`default_nettype none
module serial_chan_ctrl_chk (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // bus
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // status
  input wire logic [1:0] run_status_o,
  input wire logic [1:0] comm_wait_o,
  input wire logic [1:0] abort_o,
  input wire logic irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  // read address taken this edge
  logic ar_hs;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  // answers stand until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer moved early");
  // start trigger reads as zero, unmapped reads refused
  property p_start_zero;
    ar_hs && s_axi_araddr[23:0] == {2'b00, sch_pkg::START_TRIG_ADDR}
      |=> s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == sch_pkg::RESP_OKAY;
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("start read not zero");
  property p_unmapped;
    ar_hs && s_axi_araddr[23:0] == 24'h0 |=> s_axi_rresp == sch_pkg::RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  // wait implies running; a channel starts straight into wait
  property p_wait_run;
    (comm_wait_o & ~run_status_o) == 2'h0;
  endproperty
  a_wait_run: assert property (p_wait_run) else $error("wait without run");
  property p_rise_wait;
    (run_status_o & ~$past(run_status_o) & ~comm_wait_o) == 2'h0;
  endproperty
  a_rise_wait: assert property (p_rise_wait) else $error("start not in wait");
  // restart abort is a single pulse of a running channel, back to wait
  property p_abort_run;
    (abort_o & ~run_status_o) == 2'h0;
  endproperty
  a_abort_run: assert property (p_abort_run) else $error("abort on idle channel");
  property p_abort_once;
    (abort_o & $past(abort_o)) == 2'h0;
  endproperty
  a_abort_once: assert property (p_abort_once) else $error("abort longer than one");
  property p_abort_wait;
    abort_o[0] |-> ##[0:2] comm_wait_o[0];
  endproperty
  a_abort_wait: assert property (p_abort_wait) else $error("abort not to wait");
  // main scenarios
  c_abort: cover property (abort_o[0]);
  c_irq: cover property ($rose(irq_o));
  c_run1: cover property ($rose(run_status_o[1]));
endmodule // serial_chan_ctrl_chk
bind serial_chan_ctrl serial_chan_ctrl_chk u_chk (.mclk_i, .nrst_i, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .run_status_o, .comm_wait_o, .abort_o, .irq_o);
`default_nettype wire

/* bench/serial_chan_ctrl_tb_top.sv */
// Purpose: self-checking bench for serial_chan_ctrl
// Assumes: 20 MHz clock, inputs driven on rising edges
// Notes: scenarios run in order from one initial block
`timescale 1ns/1ps
`default_nettype none
module serial_chan_ctrl_tb_top;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ab_seen = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, run_status_o, comm_wait_o, abort_o, receive_enable_o;
  logic [1:0] rx_done_i, parity_bad_i, stop_missing_i, data_reg_write_i, data_reg_read_i;
  logic [1:0] tx_need_i, tx_supplied_i;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  localparam logic [1:0] OK = sch_pkg::RESP_OKAY;
  serial_chan_ctrl u_dut (.mclk_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_done_i, .parity_bad_i, .stop_missing_i,
    .data_reg_write_i, .data_reg_read_i, .tx_need_i, .tx_supplied_i, .run_status_o,
    .comm_wait_o, .abort_o, .receive_enable_o, .irq_o);
  serial_peer_model u_peer (.mclk_i, .rx_done_o(rx_done_i), .parity_bad_o(parity_bad_i),
    .stop_missing_o(stop_missing_i), .data_wr_o(data_reg_write_i),
    .data_rd_o(data_reg_read_i), .tx_need_o(tx_need_i), .tx_supplied_o(tx_supplied_i));
  // clock, abort catcher, watchdog
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (abort_o[0]) ab_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  task summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // bus write; address and data released as each is taken
  task wr(input logic [21:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    @(posedge mclk_i);
    s_axi_awaddr <= {10'h000, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  // bus read and compare; data ignored on a refusal
  task rdc(input logic [21:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge mclk_i);
    s_axi_araddr <= {10'h000, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    if (r === OK) chk(s_axi_rdata, d);
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  task t_reset_and_map();
    rdc(sch_pkg::START_TRIG_ADDR, 32'h0, OK);
    rdc(22'h0, 32'h0, sch_pkg::RESP_SLVERR);
    wr(22'h0, 32'hffff_ffff, 4'hf, sch_pkg::RESP_SLVERR);
    rdc(sch_pkg::RUN_STAT_ADDR, 32'h0, OK);
  endtask
  task t_start_halt();
    wr(sch_pkg::START_TRIG_ADDR, 32'h1, 4'h3, OK);
    tick(2);
    chk(32'({run_status_o, comm_wait_o}), 32'h5);
    rdc(sch_pkg::START_TRIG_ADDR, 32'h0, OK);
    wr(sch_pkg::START_TRIG_ADDR, 32'h2, 4'h1, OK);
    tick(2);
    rdc(sch_pkg::RUN_STAT_ADDR, 32'h3, OK);
    wr(sch_pkg::HALT_TRIG_ADDR, 32'h3, 4'hf, OK);
    tick(6);
    chk(32'(run_status_o), 32'h0);
  endtask
  task t_flags_restart();
    wr(sch_pkg::IRQ_EN_ADDR, 32'h3f, 4'hf, OK);
    wr(sch_pkg::CONFIG_ADDR, 32'h1, 4'hf, OK);
    tick(4);
    chk(32'(receive_enable_o), 32'h1);
    wr(sch_pkg::START_TRIG_ADDR, 32'h1, 4'h3, OK);
    u_peer.ev(0, 0, 2'b11);
    u_peer.ev(0, 2, 2'b00);
    tick(1);
    chk(32'(irq_o), 32'h1);
    rdc(sch_pkg::STATE0_ADDR, 32'h2, OK);
    u_peer.ev(1, 0, 2'b01);
    rdc(sch_pkg::STATE1_ADDR, 32'h4, OK);
    u_peer.ev(0, 0, 2'b00);
    u_peer.ev(0, 1, 2'b00);
    rdc(sch_pkg::STATE0_ADDR, 32'h3, OK);
    wr(sch_pkg::START_TRIG_ADDR, 32'h1, 4'h3, OK);
    tick(4);
    chk(32'({ab_seen, comm_wait_o[0]}), 32'h3);
    rdc(sch_pkg::STATE0_ADDR, 32'h3, OK);
    rdc(sch_pkg::CONFIG_ADDR, 32'h1, OK);
    wr(sch_pkg::CLEAR0_ADDR, 32'h2, 4'hf, OK);
    rdc(sch_pkg::STATE0_ADDR, 32'h1, OK);
    wr(sch_pkg::CLEAR0_ADDR, 32'h1, 4'hf, OK);
    rdc(sch_pkg::STATE0_ADDR, 32'h0, OK);
  endtask
  task t_slave_irq();
    wr(sch_pkg::CONFIG_ADDR, 32'h601, 4'hf, OK);
    wr(sch_pkg::START_TRIG_ADDR, 32'h2, 4'h3, OK);
    u_peer.ev(1, 3, 2'b01);
    rdc(sch_pkg::STATE1_ADDR, 32'h4, OK);
    u_peer.ev(1, 3, 2'b00);
    rdc(sch_pkg::STATE1_ADDR, 32'h5, OK);
    rdc(sch_pkg::IRQ_STAT_ADDR, 32'h2b, OK);
    wr(sch_pkg::IRQ_EN_ADDR, 32'h0, 4'hf, OK);
    tick(2);
    chk(32'(irq_o), 32'h0);
    wr(sch_pkg::IRQ_EN_ADDR, 32'h3f, 4'hf, OK);
    wr(sch_pkg::IRQ_CLR_ADDR, 32'h3f, 4'hf, OK);
    tick(2);
    chk(32'(irq_o), 32'h0);
    rdc(sch_pkg::IRQ_STAT_ADDR, 32'h0, OK);
  endtask
  // reset for five cycles, then the scenarios
  initial begin
    tick(5);
    nrst_i <= 1'b1;
    tick(3);
    t_reset_and_map();
    t_start_halt();
    t_flags_restart();
    t_slave_irq();
    summarize();
  end
endmodule // serial_chan_ctrl_tb_top
`default_nettype wire

/* bench/serial_peer_model.sv */
// Purpose: transfer engine and remote peer stand-in
// Assumes: one event at a time through ev
// Notes: qualifiers show the inverse outside a pulse
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
  // clock
  input wire logic mclk_i,
  // per channel events and qualifiers
  output logic [1:0] rx_done_o,
  output logic [1:0] parity_bad_o,
  output logic [1:0] stop_missing_o,
  output logic [1:0] data_wr_o,
  output logic [1:0] data_rd_o,
  output logic [1:0] tx_need_o,
  output logic [1:0] tx_supplied_o
);
  // pulse kinds: rx end, data write, data read, transmit need
  logic [1:0] pulse_q [4] = '{default: 2'h0};
  assign rx_done_o = pulse_q[0];
  assign data_wr_o = pulse_q[1];
  assign data_rd_o = pulse_q[2];
  assign tx_need_o = pulse_q[3];
  initial {parity_bad_o, stop_missing_o, tx_supplied_o} = 6'h0;
  // one-cycle event; stale qualifiers would hide a sampling slip
  task ev(input int c, input int k, input logic [1:0] q);
    @(posedge mclk_i);
    pulse_q[k][c] <= 1'b1;
    {parity_bad_o[c], stop_missing_o[c], tx_supplied_o[c]} <= {q, q[0]};
    @(posedge mclk_i);
    pulse_q[k][c] <= 1'b0;
    {parity_bad_o[c], stop_missing_o[c], tx_supplied_o[c]} <= ~{q, q[0]};
  endtask
endmodule // serial_peer_model
`default_nettype wire

/* verilog/chan_flags.sv */
// Purpose: error flags of one serial channel
// Assumes: events are one-cycle pulses on mclk_i
// Notes: set beats clear when both land in one cycle
`timescale 1ns/1ps
`default_nettype none
module chan_flags (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // events
  input wire logic par_evt_i,
  input wire logic ovr_evt_i,
  input wire logic frm_evt_i,
  // clears
  input wire logic par_clr_i,
  input wire logic ovr_clr_i,
  input wire logic frm_clr_i,
  // flags
  output logic [2:0] flags_o
);
  // sticky flags, set priority
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= 3'h0;
    end else begin
      flags_o[sch_pkg::PAR_BIT] <= par_evt_i | (flags_o[sch_pkg::PAR_BIT] & ~par_clr_i); // see R1 R2 R18
      flags_o[sch_pkg::OVR_BIT] <= ovr_evt_i | (flags_o[sch_pkg::OVR_BIT] & ~ovr_clr_i); // see R3 R18
      flags_o[sch_pkg::FRM_BIT] <= frm_evt_i | (flags_o[sch_pkg::FRM_BIT] & ~frm_clr_i); // see R16
    end
  end
endmodule // chan_flags
`default_nettype wire

/* verilog/sch_pkg.sv */
// Purpose: shared constants for the two-channel serial start and error flag block
// Assumes: AXI4-Lite register access, 32-bit words, one aligned word per register
// Notes: printed offsets are not all multiples of four, so register indexes are kept
package sch_pkg;
  // printed offset of the start trigger (index); byte address is four times it
  localparam logic [19:0] START_TRIG_IDX = 20'hf0122;
  localparam logic [21:0] START_TRIG_ADDR = {START_TRIG_IDX, 2'b00};
  // own registers, byte addresses in the low 22 address bits
  localparam logic [21:0] HALT_TRIG_ADDR = 22'h3c0490;
  localparam logic [21:0] RUN_STAT_ADDR = 22'h3c0494;
  localparam logic [21:0] CONFIG_ADDR = 22'h3c0498;
  localparam logic [21:0] STATE0_ADDR = 22'h3c049c;
  localparam logic [21:0] STATE1_ADDR = 22'h3c04a0;
  localparam logic [21:0] CLEAR0_ADDR = 22'h3c04a4;
  localparam logic [21:0] CLEAR1_ADDR = 22'h3c04a8;
  localparam logic [21:0] IRQ_STAT_ADDR = 22'h3c04ac;
  localparam logic [21:0] IRQ_CLR_ADDR = 22'h3c04b0;
  localparam logic [21:0] IRQ_EN_ADDR = 22'h3c04b4;
  // state/clear field positions
  localparam int OVR_BIT = 0;
  localparam int PAR_BIT = 1;
  localparam int FRM_BIT = 2;
  // config field positions: rx enable, slave mode, slave transmit
  localparam int RXE_BIT = 0;
  localparam int SLV_BIT = 1;
  localparam int STX_BIT = 2;
  localparam logic [15:0] TRIG_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // channel phase encoding
  typedef enum logic [1:0] {
    PH_STOP = 2'b00,
    PH_WAIT = 2'b01,
    PH_BUSY = 2'b10
  } phase_type;
endpackage

/* verilog/serial_chan_ctrl.sv */
// Purpose: start/halt triggers, run status and error flags of a two-channel serial unit
// Assumes: transfer engines outside report completion events as one-cycle pulses
// Notes: registers over AXI4-Lite; interrupt on flag set events
// Overview of operation
// R1: parity mismatch at asynchronous receive end sets the channel parity error flag.
// R2: writing one to parity clear trigger clears the parity error flag.
// R3: writing one to overrun clear trigger clears the overrun flag.
// R4: overwriting unread received word while receive enabled sets overrun flag.
// R5: slave clocked transmit without supplied data sets overrun flag.
// R6: start trigger one sets run status and enters communication wait.
// R7: start trigger clears itself once run status is one.
// R8: reading the start trigger register always returns zeros.
// R9: reset clears the start trigger register.
// R10: start trigger during communication stops transfer and returns to wait.
// R11: restart keeps config, shift data, pin levels and error flags.
// R12: software waits four clocks after receive enable before starting reception.
// R13: software writes zeros to start trigger bits 15 to 2.
// R14: start trigger accepts 16-bit writes and byte writes of the low byte.
// R15: exactly two channels, each with trigger, run status and flags.
// R16: missing stop bit sets framing flag, implemented on channel 1 only.
// R17: halt trigger one clears run status, stopping the channel.
// R18: flags hold until set or clear; set wins over clear.
`timescale 1ns/1ps
`default_nettype none
module serial_chan_ctrl (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // axi4-lite write address / data / response
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transfer engine events, per channel
  input wire logic [1:0] rx_done_i,
  input wire logic [1:0] parity_bad_i,
  input wire logic [1:0] stop_missing_i,
  input wire logic [1:0] data_reg_write_i,
  input wire logic [1:0] data_reg_read_i,
  input wire logic [1:0] tx_need_i,
  input wire logic [1:0] tx_supplied_i,
  // channel status to the engines
  output logic [1:0] run_status_o,
  output logic [1:0] comm_wait_o,
  output logic [1:0] abort_o,
  output logic [1:0] receive_enable_o,
  // interrupt
  output logic irq_o
);
  logic rst_s1_reg;
  logic rst_n_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [21:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;
  logic [15:0] wr_half;
  logic [1:0] start_trig_reg;
  logic [1:0] halt_trig_reg;
  logic [2:0] config_reg [2];
  logic [1:0] unread_reg;
  sch_pkg::phase_type phase_reg [2];
  logic [2:0] flags [2];
  logic [2:0] clr [2];
  logic [5:0] irq_stat_reg;
  logic [5:0] irq_en_reg;
  logic [5:0] irq_clr;
  logic [5:0] set_evt;
  logic [1:0] par_evt;
  logic [1:0] ovr_evt;
  logic [1:0] frm_evt;
  logic [31:0] rd_next;
  logic rd_ok;

  // byte-lane merge of a 16-bit write, low byte alone is allowed
  function automatic logic [15:0] lanes(input logic [31:0] d, input logic [3:0] s);
    lanes = {s[1] ? d[15:8] : 8'h00, s[0] ? d[7:0] : 8'h00};
  endfunction

  // byte-address match on the held address; bits above 21 are ignored
  function automatic logic hit(input logic [21:0] a, input logic [21:0] r);
    hit = (a == r);
  endfunction

  // reset release through two flops
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // write channel capture; address and data may come in either order
  assign wr_go = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  assign wr_half = lanes(w_data_reg, w_strb_reg); // see R14
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 22'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sch_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold_reg & ~s_axi_awready;
      s_axi_wready <= ~w_hold_reg & ~s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[21:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (rd_map(aw_addr_reg) || hit(aw_addr_reg, sch_pkg::CLEAR0_ADDR)
          || hit(aw_addr_reg, sch_pkg::CLEAR1_ADDR) || hit(aw_addr_reg, sch_pkg::IRQ_CLR_ADDR)
          || hit(aw_addr_reg, sch_pkg::HALT_TRIG_ADDR))
          ? sch_pkg::RESP_OKAY : sch_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end
    end
  end

  // addresses that answer a read
  function automatic logic rd_map(input logic [21:0] a);
    rd_map = hit(a, sch_pkg::START_TRIG_ADDR) || hit(a, sch_pkg::RUN_STAT_ADDR)
      || hit(a, sch_pkg::CONFIG_ADDR) || hit(a, sch_pkg::STATE0_ADDR)
      || hit(a, sch_pkg::STATE1_ADDR) || hit(a, sch_pkg::IRQ_STAT_ADDR)
      || hit(a, sch_pkg::IRQ_EN_ADDR);
  endfunction

  // start and halt triggers: self-clearing once run status follows
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      start_trig_reg <= sch_pkg::TRIG_RESET[1:0]; // see R9
      halt_trig_reg <= 2'b00;
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (start_trig_reg[n] && run_status_o[n]) start_trig_reg[n] <= 1'b0; // see R7
        if (halt_trig_reg[n] && !run_status_o[n]) halt_trig_reg[n] <= 1'b0;
      end
      // upper bits 15..2 are ignored on write
      if (wr_go && hit(aw_addr_reg, sch_pkg::START_TRIG_ADDR)) begin
        start_trig_reg <= wr_half[1:0]; // see R14 R15
      end
      if (wr_go && hit(aw_addr_reg, sch_pkg::HALT_TRIG_ADDR)) begin
        halt_trig_reg <= wr_half[1:0];
      end
    end
  end

  // run status and phase; halt wins over a start in the same write window
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      run_status_o <= 2'b00;
      comm_wait_o <= 2'b00;
      abort_o <= 2'b00;
      phase_reg[0] <= sch_pkg::PH_STOP;
      phase_reg[1] <= sch_pkg::PH_STOP;
    end else begin
      for (int n = 0; n < 2; n++) begin
        abort_o[n] <= 1'b0;
        if (halt_trig_reg[n]) begin
          run_status_o[n] <= 1'b0; // see R17
          phase_reg[n] <= sch_pkg::PH_STOP;
          comm_wait_o[n] <= 1'b0;
        end else if (start_trig_reg[n] && !run_status_o[n]) begin
          run_status_o[n] <= 1'b1; // see R6
          phase_reg[n] <= sch_pkg::PH_WAIT;
          comm_wait_o[n] <= 1'b1;
        end else if (start_trig_reg[n]) begin
          // restart touches phase, comm_wait_o and abort_o only; flags and config kept
          abort_o[n] <= (phase_reg[n] == sch_pkg::PH_BUSY); // see R10 R11
          phase_reg[n] <= sch_pkg::PH_WAIT;
          comm_wait_o[n] <= 1'b1;
        end else begin
          case (phase_reg[n])
            sch_pkg::PH_WAIT: begin
              if (data_reg_write_i[n] || tx_need_i[n]) begin
                phase_reg[n] <= sch_pkg::PH_BUSY;
                comm_wait_o[n] <= 1'b0;
              end
            end
            sch_pkg::PH_BUSY: phase_reg[n] <= sch_pkg::PH_BUSY;
            sch_pkg::PH_STOP: phase_reg[n] <= sch_pkg::PH_STOP;
            default: phase_reg[n] <= sch_pkg::PH_STOP;
          endcase
        end
      end
    end
  end

  // per-channel config: receive enable, slave, slave transmit
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      config_reg[0] <= 3'h0;
      config_reg[1] <= 3'h0;
    end else if (wr_go && hit(aw_addr_reg, sch_pkg::CONFIG_ADDR)) begin
      config_reg[0] <= w_data_reg[2:0];
      config_reg[1] <= w_data_reg[10:8];
    end
  end
  assign receive_enable_o = {config_reg[1][sch_pkg::RXE_BIT], config_reg[0][sch_pkg::RXE_BIT]};

  // unread received word tracking
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      unread_reg <= 2'b00;
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (rx_done_i[n]) unread_reg[n] <= 1'b1;
        else if (data_reg_read_i[n]) unread_reg[n] <= 1'b0;
      end
    end
  end

  // error events
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      par_evt[n] = rx_done_i[n] & parity_bad_i[n]; // see R1
      ovr_evt[n] = (unread_reg[n] & config_reg[n][sch_pkg::RXE_BIT]
        & (rx_done_i[n] | data_reg_write_i[n])) // see R4
        | (config_reg[n][sch_pkg::SLV_BIT] & config_reg[n][sch_pkg::STX_BIT]
        & tx_need_i[n] & ~tx_supplied_i[n]); // see R5
      frm_evt[n] = (n == 1) & rx_done_i[n] & stop_missing_i[n]; // see R16
      clr[n] = (wr_go && hit(aw_addr_reg, n == 0 ? sch_pkg::CLEAR0_ADDR : sch_pkg::CLEAR1_ADDR))
        ? wr_half[2:0] : 3'h0; // see R2 R3
    end
  end

  // one flag block per channel
  for (genvar g = 0; g < 2; g++) begin : g_ch
    chan_flags u_flags (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_reg),
      .par_evt_i(par_evt[g]),
      .ovr_evt_i(ovr_evt[g]),
      .frm_evt_i(frm_evt[g]),
      .par_clr_i(clr[g][sch_pkg::PAR_BIT]),
      .ovr_clr_i(clr[g][sch_pkg::OVR_BIT]),
      .frm_clr_i(clr[g][sch_pkg::FRM_BIT]),
      .flags_o(flags[g])
    );
  end

  // interrupt status: set wins over clear
  assign set_evt = {frm_evt[1], par_evt[1], ovr_evt[1], frm_evt[0], par_evt[0], ovr_evt[0]};
  assign irq_clr = (wr_go && hit(aw_addr_reg, sch_pkg::IRQ_CLR_ADDR)) ? w_data_reg[5:0] : 6'h0;
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_stat_reg <= 6'h0;
      irq_en_reg <= 6'h0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_reg <= set_evt | (irq_stat_reg & ~irq_clr);
      if (wr_go && hit(aw_addr_reg, sch_pkg::IRQ_EN_ADDR)) irq_en_reg <= w_data_reg[5:0];
      irq_o <= |((set_evt | (irq_stat_reg & ~irq_clr)) & irq_en_reg);
    end
  end

  // read mux
  always_comb begin
    rd_next = 32'h0;
    rd_ok = 1'b1;
    case (s_axi_araddr[21:0])
      sch_pkg::START_TRIG_ADDR: rd_next = 32'h0; // see R8
      sch_pkg::RUN_STAT_ADDR: rd_next = {30'h0, run_status_o};
      sch_pkg::CONFIG_ADDR: rd_next = {21'h0, config_reg[1], 5'h0, config_reg[0]};
      sch_pkg::STATE0_ADDR: rd_next = {29'h0, 1'b0, flags[0][1:0]};
      sch_pkg::STATE1_ADDR: rd_next = {29'h0, flags[1]};
      sch_pkg::IRQ_STAT_ADDR: rd_next = {26'h0, irq_stat_reg};
      sch_pkg::IRQ_EN_ADDR: rd_next = {26'h0, irq_en_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  // read channel: one answer at a time
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= sch_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & ~s_axi_arvalid;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) s_axi_arready <= 1'b1;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_next;
        s_axi_rresp <= rd_ok ? sch_pkg::RESP_OKAY : sch_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // serial_chan_ctrl
`default_nettype wire
